// [hdl/tps_pkg.sv]
// Package for the TMDS switch parallel-control decoder
package tps_pkg;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [3:0] TPS_REG_CTRL = 4'h0;
    localparam logic [3:0] TPS_REG_SERIAL = 4'h4;
    localparam logic [3:0] TPS_REG_STATUS = 4'h8;
    // CTRL fields
    localparam int TPS_CTRL_MODE_BIT = 0;
    // SERIAL fields
    localparam int TPS_SER_IN_TERM_BIT = 0;
    localparam int TPS_SER_OUT_TERM_BIT = 1;
    localparam int TPS_SER_EQ_BIT = 2;
    localparam int TPS_SER_PE_LSB = 3;
    localparam int TPS_SER_OCL_BIT = 5;
    localparam int TPS_SER_SRC_LSB = 6;
    localparam int TPS_SER_EN_BIT = 8;
    // Reset values
    localparam logic TPS_CTRL_RESET = 1'b0;
    localparam logic [8:0] TPS_SERIAL_RESET = 9'h000;
    // Encodings
    localparam logic TPS_EQ_LOW_6DB = 1'b0;
    localparam logic TPS_EQ_HIGH_12DB = 1'b1;
    localparam logic [1:0] TPS_PE_0DB = 2'h0;
    localparam logic [1:0] TPS_PE_2DB = 2'h1;
    localparam logic [1:0] TPS_PE_4DB = 2'h2;
    localparam logic [1:0] TPS_PE_6DB = 2'h3;
    localparam logic TPS_OCL_10MA = 1'b0;
    localparam logic TPS_OCL_20MA = 1'b1;
    localparam int TPS_NUM_CH = 4;

    typedef enum logic [1:0] {
        TPS_SRC_A,
        TPS_SRC_B,
        TPS_SRC_C,
        TPS_SRC_D
    } tps_src_t;

    // Analog control word as applied to the receivers and transmitters
    typedef struct packed {
        logic hs_on;
        tps_src_t src;
        logic [TPS_NUM_CH-1:0] eq_high;
        logic [TPS_NUM_CH-1:0] in_term_on;
        logic [TPS_NUM_CH-1:0] term_pulse_on;
        logic [1:0] preemph;
        logic out_term_on;
        logic out_current_hi;
    } tps_analog_t;

    // Parallel control inputs grouped
    typedef struct packed {
        logic par_high_speed_on;
        logic [1:0] par_source_select;
        logic par_input_eq_level;
        logic [1:0] par_output_preemph_level;
        logic par_output_term_on;
        logic par_output_current_level;
    } tps_par_t;
endpackage : tps_pkg

// [hdl/tps_chan_route.sv]
// One output channel's positional source selector
`timescale 1ns/10ps
`default_nettype none
module tps_chan_route
    import tps_pkg::*;
(
    // Source lanes of this channel position
    input wire logic [3:0] lane_in,
    // Selection
    input wire tps_src_t src,
    input wire logic hs_on,
    // Result
    output logic lane_out
);
    // Channel n only ever sees lane n of A..D
    always_comb begin
        lane_out = hs_on & lane_in[src];
    end
endmodule // tps_chan_route
`default_nettype wire

// [hdl/tps_switch_cfg.sv]
// Decoder of TMDS switch controls with channel routing
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module tps_switch_cfg
    import tps_pkg::*;
#(
    parameter int NUM_CH = TPS_NUM_CH
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Parallel control levels
    input wire tps_par_t par_in,
    // High speed lanes, source-major: [src*NUM_CH + ch]
    input wire logic [4*NUM_CH-1:0] hs_lane_in,
    // Auxiliary lanes, same layout
    input wire logic [4*NUM_CH-1:0] aux_lane_in,
    // Applied controls and routed lanes
    output tps_analog_t analog_out,
    output logic [NUM_CH-1:0] hs_lane_out,
    output logic [NUM_CH-1:0] aux_lane_out
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic serial_mode;
        logic [8:0] serial;
        tps_analog_t analog;
        logic [31:0] rdata;
        logic [NUM_CH-1:0] hs_out;
        logic [NUM_CH-1:0] aux_out;
    } tps_state_t;

    tps_state_t st_r;
    tps_state_t st_nxt;
    tps_analog_t dec;
    logic [NUM_CH-1:0] hs_route;
    logic [NUM_CH-1:0] aux_route;

    // ----------------------------------------------------------------
    // Decode of the active control source
    // ----------------------------------------------------------------
    always_comb begin
        if (st_r.serial_mode) begin
            dec.hs_on = st_r.serial[TPS_SER_EN_BIT];
            dec.src = tps_src_t'(st_r.serial[TPS_SER_SRC_LSB +: 2]);
            dec.eq_high = {NUM_CH{st_r.serial[TPS_SER_EQ_BIT]}};
            dec.in_term_on = {NUM_CH{st_r.serial[TPS_SER_IN_TERM_BIT]}};
            dec.term_pulse_on = '0;
            dec.preemph = st_r.serial[TPS_SER_PE_LSB +: 2];
            dec.out_term_on = st_r.serial[TPS_SER_OUT_TERM_BIT];
            dec.out_current_hi = st_r.serial[TPS_SER_OCL_BIT];
        end else begin
            dec.hs_on = par_in.par_high_speed_on;
            dec.src = tps_src_t'(par_in.par_source_select);
            dec.eq_high = {NUM_CH{par_in.par_input_eq_level}};
            dec.in_term_on = '1;
            dec.term_pulse_on = '0;
            dec.preemph = par_in.par_output_preemph_level;
            dec.out_term_on = par_in.par_output_term_on;
            dec.out_current_hi = par_in.par_output_current_level;
        end
    end

    // ----------------------------------------------------------------
    // Positional routing, one identical slice per channel
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            tps_chan_route u_hs (
                .lane_in({hs_lane_in[3*NUM_CH+g], hs_lane_in[2*NUM_CH+g],
                          hs_lane_in[NUM_CH+g], hs_lane_in[g]}),
                .src(dec.src),
                .hs_on(dec.hs_on),
                .lane_out(hs_route[g])
            );
            tps_chan_route u_aux (
                .lane_in({aux_lane_in[3*NUM_CH+g], aux_lane_in[2*NUM_CH+g],
                          aux_lane_in[NUM_CH+g], aux_lane_in[g]}),
                .src(dec.src),
                .hs_on(1'b1),
                .lane_out(aux_route[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Next state and register port
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.analog = dec;
        st_nxt.hs_out = hs_route;
        st_nxt.aux_out = aux_route;
        st_nxt.rdata = '0;
        if (reg_wr) begin
            if (reg_addr == TPS_REG_CTRL) begin
                st_nxt.serial_mode = reg_wdata[TPS_CTRL_MODE_BIT];
            end else if (reg_addr == TPS_REG_SERIAL) begin
                st_nxt.serial = reg_wdata[8:0];
            end
        end
        if (reg_rd) begin
            if (reg_addr == TPS_REG_CTRL) begin
                st_nxt.rdata = {31'h0, st_r.serial_mode};
            end else if (reg_addr == TPS_REG_SERIAL) begin
                st_nxt.rdata = {23'h0, st_r.serial};
            end else if (reg_addr == TPS_REG_STATUS) begin
                st_nxt.rdata = {{(32 - $bits(tps_analog_t)){1'b0}}, st_r.analog};
            end else begin
                st_nxt.rdata = '0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.serial_mode <= TPS_CTRL_RESET;
            st_r.serial <= TPS_SERIAL_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rdata;
    assign analog_out = st_r.analog;
    assign hs_lane_out = st_r.hs_out;
    assign aux_lane_out = st_r.aux_out;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_pulse_always_off: assert property (
        ##1 analog_out.term_pulse_on == '0)
        else $error("termination pulse enabled");
    a_eq_all_same: assert property (
        !st_r.serial_mode && !$past(st_r.serial_mode) |=>
        analog_out.eq_high == {NUM_CH{$past(par_in.par_input_eq_level)}})
        else $error("equalization not uniform");
    a_eq_level_map: assert property (
        !st_r.serial_mode && par_in.par_input_eq_level == TPS_EQ_HIGH_12DB |=>
        analog_out.eq_high[0] == TPS_EQ_HIGH_12DB)
        else $error("equalization level wrong");
    a_preemph_map: assert property (
        !st_r.serial_mode |=> analog_out.preemph == $past(par_in.par_output_preemph_level))
        else $error("pre-emphasis wrong");
    a_out_term_map: assert property (
        !st_r.serial_mode |=> analog_out.out_term_on == $past(par_in.par_output_term_on))
        else $error("output termination wrong");
    a_current_map: assert property (
        !st_r.serial_mode |=> analog_out.out_current_hi == $past(par_in.par_output_current_level))
        else $error("output current wrong");
    a_route_pos: assert property (
        !st_r.serial_mode && par_in.par_high_speed_on && par_in.par_source_select == 2'h2 |=>
        hs_lane_out[0] == $past(hs_lane_in[2*NUM_CH]))
        else $error("positional routing wrong");
    a_standby_off: assert property (
        !st_r.serial_mode && !par_in.par_high_speed_on |=> hs_lane_out == '0)
        else $error("lanes active in standby");
    a_aux_route: assert property (
        !st_r.serial_mode && par_in.par_source_select == 2'h1 |=>
        aux_lane_out[1] == $past(aux_lane_in[NUM_CH+1]))
        else $error("auxiliary routing wrong");
    a_serial_term: assert property (
        st_r.serial_mode |=> analog_out.in_term_on[0] == $past(st_r.serial[TPS_SER_IN_TERM_BIT]))
        else $error("serial input termination wrong");

    // ----------------------------------------------------------------
    // Checks, parallel decode
    // ----------------------------------------------------------------
    // Strap levels show up on the controls one edge after they are sampled
    a_eq_low_map: assert property (
        !st_r.serial_mode && par_in.par_input_eq_level == TPS_EQ_LOW_6DB |=>
        analog_out.eq_high == '0)
        else $error("low equalization not applied");
    a_hs_on_map: assert property (
        !st_r.serial_mode |=> analog_out.hs_on == $past(par_in.par_high_speed_on))
        else $error("high speed enable wrong");
    a_src_map: assert property (
        !st_r.serial_mode |=> analog_out.src == $past(par_in.par_source_select))
        else $error("source select wrong");
    a_pulse_par_off: assert property (
        !st_r.serial_mode |=> analog_out.term_pulse_on == '0)
        else $error("termination pulse enabled in parallel mode");

    // ----------------------------------------------------------------
    // Checks, serial mode
    // ----------------------------------------------------------------
    // The stored serial word takes effect one edge after it is stored
    a_ser_in_term_all: assert property (
        st_r.serial_mode |=>
        analog_out.in_term_on == {NUM_CH{$past(st_r.serial[TPS_SER_IN_TERM_BIT])}})
        else $error("serial input termination not uniform");
    a_ser_out_term: assert property (
        st_r.serial_mode |=> analog_out.out_term_on == $past(st_r.serial[TPS_SER_OUT_TERM_BIT]))
        else $error("serial output termination wrong");
    a_ser_eq: assert property (
        st_r.serial_mode |=>
        analog_out.eq_high == {NUM_CH{$past(st_r.serial[TPS_SER_EQ_BIT])}})
        else $error("serial equalization wrong");
    a_ser_preemph: assert property (
        st_r.serial_mode |=> analog_out.preemph == $past(st_r.serial[TPS_SER_PE_LSB +: 2]))
        else $error("serial pre-emphasis wrong");
    a_ser_current: assert property (
        st_r.serial_mode |=> analog_out.out_current_hi == $past(st_r.serial[TPS_SER_OCL_BIT]))
        else $error("serial output current wrong");
    a_ser_hs_on: assert property (
        st_r.serial_mode |=> analog_out.hs_on == $past(st_r.serial[TPS_SER_EN_BIT]))
        else $error("serial high speed enable wrong");
    a_ser_src: assert property (
        st_r.serial_mode |=> analog_out.src == $past(st_r.serial[TPS_SER_SRC_LSB +: 2]))
        else $error("serial source select wrong");

    // ----------------------------------------------------------------
    // Checks, register port
    // ----------------------------------------------------------------
    // Read data live for exactly the cycle after the read strobe
    a_rdata_idle: assert property (
        !reg_rd |=> reg_rdata == '0)
        else $error("read data outside read cycle");
    a_rd_ctrl: assert property (
        reg_rd && reg_addr == TPS_REG_CTRL |=> reg_rdata == 32'($past(st_r.serial_mode)))
        else $error("mode read back wrong");
    a_rd_serial: assert property (
        reg_rd && reg_addr == TPS_REG_SERIAL |=> reg_rdata == 32'($past(st_r.serial)))
        else $error("serial word read back wrong");
    a_rd_status: assert property (
        reg_rd && reg_addr == TPS_REG_STATUS |=> reg_rdata == 32'($past(analog_out)))
        else $error("status read back wrong");
    a_rd_unmapped: assert property (
        reg_rd && reg_addr != TPS_REG_CTRL && reg_addr != TPS_REG_SERIAL &&
        reg_addr != TPS_REG_STATUS |=> reg_rdata == '0)
        else $error("unmapped read not zero");
    a_wr_mode: assert property (
        reg_wr && reg_addr == TPS_REG_CTRL |=>
        st_r.serial_mode == $past(reg_wdata[TPS_CTRL_MODE_BIT]))
        else $error("mode write lost");
    a_wr_serial: assert property (
        reg_wr && reg_addr == TPS_REG_SERIAL |=> st_r.serial == $past(reg_wdata[8:0]))
        else $error("serial word write lost");
    // Writes elsewhere, the status word included, must leave the settings alone
    a_wr_ignored: assert property (
        reg_wr && reg_addr != TPS_REG_CTRL && reg_addr != TPS_REG_SERIAL |=>
        $stable(st_r.serial_mode) && $stable(st_r.serial))
        else $error("ignored write changed settings");

    // ----------------------------------------------------------------
    // Checks, per-channel routing
    // ----------------------------------------------------------------
    // Every slice is held to the same check, so no channel is special
    // Lanes follow the source picked at the previous edge
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_chk
            a_hs_lane_pos: assert property (
                dec.hs_on |=> hs_lane_out[g] == $past(hs_lane_in[int'(dec.src) * NUM_CH + g]))
                else $error("high speed lane routed from wrong source");
            a_hs_lane_off: assert property (
                !dec.hs_on |=> !hs_lane_out[g])
                else $error("high speed lane active in standby");
            a_aux_lane_pos: assert property (
                1'b1 |=> aux_lane_out[g] == $past(aux_lane_in[int'(dec.src) * NUM_CH + g]))
                else $error("auxiliary lane routed from wrong source");
        end
    endgenerate

    // ----------------------------------------------------------------
    // Cover points
    // ----------------------------------------------------------------
    c_par_src_d: cover property (!st_r.serial_mode && par_in.par_source_select == 2'h3);
    c_serial_on: cover property (st_r.serial_mode && st_r.serial[TPS_SER_OUT_TERM_BIT]);
    c_pe_high: cover property (analog_out.preemph == TPS_PE_6DB);
    c_standby: cover property (!analog_out.hs_on && !st_r.serial_mode);
    c_status_read: cover property (reg_rd && reg_addr == TPS_REG_STATUS);
endmodule // tps_switch_cfg
`default_nettype wire

// [verif/tps_strap_model.sv]
// Strap-pin model driving the parallel control levels and source lanes
`timescale 1ns/10ps
`default_nettype none
module tps_strap_model
    import tps_pkg::*;
(
    // Requested strap settings
    input wire tps_par_t set_par,
    input wire logic eq_low_ok,
    input wire logic [15:0] set_hs,
    input wire logic [15:0] set_aux,
    // Levels at the device pins
    output tps_par_t par_in,
    output logic [15:0] hs_lane_in,
    output logic [15:0] aux_lane_in
);
    // Straps are plain levels; high equalization unless low is allowed
    always_comb begin
        par_in = set_par;
        par_in.par_input_eq_level = set_par.par_input_eq_level | ~eq_low_ok;
    end
    assign hs_lane_in = set_hs;
    assign aux_lane_in = set_aux;
endmodule // tps_strap_model
`default_nettype wire

// [verif/tps_switch_cfg_tb.sv]
// Self-checking bench for the TMDS switch control decoder
`timescale 1ns/10ps
`default_nettype none
module tps_switch_cfg_tb;
    import tps_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    tps_par_t set_par = '0;
    logic eq_low_ok = 1'b1;
    logic [15:0] set_hs = 16'h0;
    logic [15:0] set_aux = 16'h0;
    tps_par_t par_in;
    logic [15:0] hs_lane_in;
    logic [15:0] aux_lane_in;
    tps_analog_t analog_out;
    logic [3:0] hs_lane_out;
    logic [3:0] aux_lane_out;
    int fail_count = 0;
    int samples_checked = 0;
    integer seed = 32'hd74e;
    logic serial_mode = 1'b0;
    logic [8:0] serial_val = 9'h0;
    logic [31:0] rd_val;

    always #5 clk_sys = ~clk_sys;

    tps_strap_model u_strap (.set_par(set_par), .eq_low_ok(eq_low_ok), .set_hs(set_hs),
        .set_aux(set_aux), .par_in(par_in), .hs_lane_in(hs_lane_in), .aux_lane_in(aux_lane_in));
    tps_switch_cfg u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .par_in(par_in), .hs_lane_in(hs_lane_in), .aux_lane_in(aux_lane_in),
        .analog_out(analog_out), .hs_lane_out(hs_lane_out), .aux_lane_out(aux_lane_out));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // Expected applied controls, from the strap levels or the serial word
    function automatic tps_analog_t model_ctl();
        tps_analog_t m;
        int hs, src, eq, pe, ot, oc, it;
        if (serial_mode) begin
            it = serial_val[0];
            ot = serial_val[1];
            eq = serial_val[2];
            pe = serial_val[4:3];
            oc = serial_val[5];
            src = serial_val[7:6];
            hs = serial_val[8];
        end else begin
            it = 1;
            ot = par_in.par_output_term_on;
            eq = par_in.par_input_eq_level;
            pe = par_in.par_output_preemph_level;
            oc = par_in.par_output_current_level;
            src = par_in.par_source_select;
            hs = par_in.par_high_speed_on;
        end
        m = '0;
        m.hs_on = hs[0];
        m.src = tps_src_t'(src[1:0]);
        m.eq_high = {4{eq[0]}};
        m.in_term_on = {4{it[0]}};
        m.preemph = pe[1:0];
        m.out_term_on = ot[0];
        m.out_current_hi = oc[0];
        return m;
    endfunction

    task automatic check_all();
        tps_analog_t m;
        logic [3:0] eh;
        logic [3:0] ea;
        m = model_ctl();
        for (int ch = 0; ch < 4; ch++) begin
            eh[ch] = m.hs_on & hs_lane_in[int'(m.src) * 4 + ch];
            ea[ch] = aux_lane_in[int'(m.src) * 4 + ch];
        end
        check(32'(analog_out), 32'(m));
        check(32'(hs_lane_out), 32'(eh));
        check(32'(aux_lane_out), 32'(ea));
    endtask

    task automatic final_report();
        $display("checked=%0d failed=%0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        #50000;
        fail_count++;
        final_report();
    end

    initial begin
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(TPS_REG_CTRL, rd_val);
        check(rd_val, 32'(TPS_CTRL_RESET));
        rd(TPS_REG_SERIAL, rd_val);
        check(rd_val, 32'(TPS_SERIAL_RESET));
        rd(4'hc, rd_val);
        check(rd_val, 32'h0);
        for (int i = 0; i < 48; i++) begin
            if (i == 24) begin
                wr(TPS_REG_CTRL, 32'h1);
                serial_mode = 1'b1;
            end
            @(posedge clk_sys);
            set_par <= tps_par_t'(8'($random(seed)));
            eq_low_ok <= 1'($random(seed));
            set_hs <= 16'($random(seed));
            set_aux <= 16'($random(seed));
            if (serial_mode) begin
                serial_val = 9'($random(seed));
                wr(TPS_REG_SERIAL, {23'h0, serial_val});
            end
            repeat (2) @(posedge clk_sys);
            #1 check_all();
            rd(TPS_REG_STATUS, rd_val);
            check(rd_val, 32'(model_ctl()));
        end
        wr(TPS_REG_STATUS, 32'hffffffff);
        wr(TPS_REG_CTRL, 32'h0);
        serial_mode = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 check_all();
        final_report();
    end
endmodule // tps_switch_cfg_tb
`default_nettype wire
